// File: hw/mvfe_defines.vh
// Constants for the measured value filter and evaluation block.
// Assumes inclusion by bare name from every design file.
`ifndef MVFE_DEFINES_VH
`define MVFE_DEFINES_VH
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define MV_MEM_DEPTH 2048
`define MV_VMAX      16'sh7fff
`define MV_VMIN      16'sh8000
// ----------------------------------------------------------------
// Filter types and difference modes
// ----------------------------------------------------------------
`define MV_FT_OFF 3'h0
`define MV_FT_AVG 3'h1
`define MV_FT_DEL 3'h2
`define MV_FT_MED 3'h3
`define MV_FT_MIN 3'h4
`define MV_FT_MAX 3'h5
`define MV_DF_RAWF 2'h1
`define MV_DF_FRAW 2'h2
// ----------------------------------------------------------------
// Series modes and link operations
// ----------------------------------------------------------------
`define MV_SM_NONE  3'h0
`define MV_SM_MINP  3'h1
`define MV_SM_MINF  3'h2
`define MV_SM_HOLDP 3'h3
`define MV_SM_HOLDF 3'h4
`define MV_SM_CYCP  3'h5
`define MV_SM_CYCF  3'h6
`define MV_LK_AND 2'h1
`define MV_LK_OR  2'h2
`define MV_LK_XOR 2'h3
`define MV_SRC_STATUS 5'h10
// ----------------------------------------------------------------
// Register offsets, blocks of eight words
// ----------------------------------------------------------------
`define MV_A_BLK  12'hfe0
`define MV_A_FCFG 12'h000
`define MV_A_ECFG 12'h020
`define MV_A_ELIM 12'h040
`define MV_A_CTRL 12'h060
`define MV_A_STAT 12'h064
`define MV_A_FVAL 12'h080
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define MV_FC_TYPE 2:0
`define MV_FC_DIFF 4:3
`define MV_FC_SRC  7:5
`define MV_FC_SIZE 17:8
`define MV_FC_BASE 28:18
`define MV_EC_SRC  4:0
`define MV_EC_INV  5
`define MV_EC_OP   7:6
`define MV_EC_MASK 15:8
`define MV_EC_MODE 18:16
`define MV_EC_N    28:19
`define MV_CT_EN   0
`define MV_CT_LINV 1
`define MV_ST_OVR  1
`define MV_RST_WORD 32'h00000000
`endif

// File: hw/mvfe_eval.v
// Eight pass/fail evaluators with linking and series counters.
// Assumes step is a one-cycle pulse once per measurement.
`timescale 1ns/1ps
`include "mvfe_defines.vh"
module mvfe_eval (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // Measurement
  input  wire         step,
  input  wire [127:0] raw,
  input  wire [127:0] filt,
  input  wire         err,
  // Configuration
  input  wire [255:0] ecfg,
  input  wire [255:0] elim,
  // Results
  output reg  [7:0]   pass_r,
  output reg          vld_r
);
  reg [9:0] cnt_r [0:7];
  reg [7:0] basic;
  reg [7:0] linked;
  reg signed [15:0] v;
  reg [31:0] c;
  integer i;
  integer j;
  integer q;

  function [10:0] series;
    input [2:0] m;
    input [9:0] n;
    input [9:0] k;
    input       l;
    reg   [9:0] n1;
    reg   [9:0] k1;
    begin
      n1 = (n == 10'h000) ? 10'h001 : n;
      k1 = (k == 10'h3ff) ? k : k + 10'h001;
      case (m)
        `MV_SM_MINP:  series = l ? {k1 >= n1, k1} : 11'h000;
        `MV_SM_MINF:  series = l ? 11'h400 : {k1 < n1, k1};
        `MV_SM_HOLDP: series = l ? {1'b1, n1 - 10'h001} :
          (k != 10'h000) ? {1'b1, k - 10'h001} : 11'h000;
        `MV_SM_HOLDF: series = !l ? {1'b0, n1 - 10'h001} :
          (k != 10'h000) ? {1'b0, k - 10'h001} : 11'h400;
        `MV_SM_CYCP:  series = (k1 >= n1) ? 11'h400 : {1'b0, k1};
        `MV_SM_CYCF:  series = (k1 >= n1) ? 11'h000 : {1'b1, k1};
        default:      series = {l, 10'h000};
      endcase
    end
  endfunction

  always @* begin
    v = 16'sh0000;
    c = 32'h0;
    for (i = 0; i < 8; i = i + 1) begin
      c = ecfg[i*32 +: 32];
      v = c[3] ? filt[c[2:0]*16 +: 16] : raw[c[2:0]*16 +: 16];
      if (c[`MV_EC_SRC] == `MV_SRC_STATUS) begin
        basic[i] = !err ^ c[`MV_EC_INV];
      end else begin
        basic[i] = ((v >= $signed(elim[i*32 +: 16])) &&
          (v <= $signed(elim[i*32+16 +: 16]))) ^ c[`MV_EC_INV];
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      c = ecfg[i*32 +: 32];
      linked[i] = basic[i];
      for (j = 0; j < 8; j = j + 1) begin
        if (c[8+j] && (j != i)) begin
          case (c[`MV_EC_OP])
            `MV_LK_AND: linked[i] = linked[i] & basic[j];
            `MV_LK_OR:  linked[i] = linked[i] | basic[j];
            `MV_LK_XOR: linked[i] = linked[i] ^ basic[j];
            default:    linked[i] = linked[i];
          endcase
        end
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pass_r <= 8'h00;
      vld_r  <= 1'b0;
      for (q = 0; q < 8; q = q + 1) begin
        cnt_r[q] <= 10'h000;
      end
    end else begin
      vld_r <= step;
      if (step) begin
        for (q = 0; q < 8; q = q + 1) begin
          {pass_r[q], cnt_r[q]} <= series(ecfg[q*32+16 +: 3],
            ecfg[q*32+19 +: 10], cnt_r[q], linked[q]);
        end
      end
    end
  end
endmodule

// File: hw/mvfe_smem.v
// Shared sample store for all filter channels.
// Assumes one writer and combinational reads on one clock.
`timescale 1ns/1ps
`include "mvfe_defines.vh"
module mvfe_smem (
  // Clock and write port
  input  wire        hclk,
  input  wire        we,
  input  wire [10:0] wa,
  input  wire [15:0] wd,
  // Read ports
  input  wire [10:0] ra0,
  input  wire [10:0] ra1,
  input  wire [10:0] ra2,
  output wire [15:0] rd0,
  output wire [15:0] rd1,
  output wire [15:0] rd2
);
  reg [15:0] mem [0:`MV_MEM_DEPTH-1];
  always @(posedge hclk) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end
  assign rd0 = mem[ra0];
  assign rd1 = mem[ra1];
  assign rd2 = mem[ra2];
endmodule

// File: hw/mvfe_top.v
// Measured value filters and pass/fail evaluation, AHB-Lite slave.
// Assumes meas_* inputs come from logic on hclk, one word per channel.
`timescale 1ns/1ps
`include "mvfe_defines.vh"
module mvfe_top (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // AHB-Lite slave
  input  wire         hsel,
  input  wire [31:0]  haddr,
  input  wire [1:0]   htrans,
  input  wire         hwrite,
  input  wire [2:0]   hsize,
  input  wire [31:0]  hwdata,
  input  wire         hready,
  output reg  [31:0]  hrdata,
  output reg          hreadyout,
  output reg          hresp,
  // Measurement input
  input  wire         meas_valid,
  input  wire [127:0] meas_vals,
  input  wire         meas_err,
  // Results
  output reg  [7:0]   dout,
  output reg  [7:0]   pass_out,
  output reg          result_valid,
  output reg          busy
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam F_IDLE  = 2'h0;
  localparam F_SETUP = 2'h1;
  localparam F_SCAN  = 2'h2;
  localparam F_NEXT  = 2'h3;

  reg  [31:0]  fcfg_r [0:7];
  reg  [31:0]  ecfg_r [0:7];
  reg  [31:0]  elim_r [0:7];
  reg  [31:0]  ctrl_r;
  reg          ovr_r;
  reg  [11:0]  addr_r;
  reg          wr_pend_r;
  reg          rd_pend_r;
  reg  [31:0]  rd_nxt;
  reg  [255:0] ecfg_flat;
  reg  [255:0] elim_flat;
  reg  [127:0] filt_flat;

  reg  [127:0] raw_r;
  reg          err_r;
  reg  [1:0]   st_r;
  reg  [2:0]   ch_r;
  reg  [9:0]   idx_r;
  reg  [9:0]   jdx_r;
  reg  [9:0]   lt_r;
  reg  [9:0]   le_r;
  reg  signed [25:0] acc_r;
  reg  signed [15:0] mn_r;
  reg  signed [15:0] mx_r;
  reg  signed [15:0] res_r [0:7];
  reg  [9:0]   wptr_r [0:7];
  reg  [9:0]   fill_r [0:7];
  reg          fdone_r;

  wire [7:0]   ev_pass;
  wire         ev_vld;
  wire [15:0]  rd_old;
  wire [15:0]  rd_x;
  wire [15:0]  rd_c;
  integer      i;
  // Own loop index per process keeps each variable single-driven
  integer      f;
  integer      r;

  function blk_hit;
    input [11:0] a;
    input [11:0] base;
    begin
      blk_hit = ((a & `MV_A_BLK) == base);
    end
  endfunction

  function signed [15:0] diff;
    input [1:0]        m;
    input signed [15:0] f;
    input signed [15:0] r;
    begin
      if (m == `MV_DF_RAWF) begin
        diff = r - f;
      end else if (m == `MV_DF_FRAW) begin
        diff = f - r;
      end else begin
        diff = f;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Reads take one wait state so a read right after a write sees it.
  wire acc_go = hsel & htrans[1] & hready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r    <= 12'h000;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= acc_go & hwrite;
      rd_pend_r <= acc_go & ~hwrite;
      if (acc_go) begin
        addr_r <= haddr[11:0];
      end
      if (acc_go & ~hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_pend_r) begin
        hreadyout <= 1'b1;
        hrdata    <= rd_nxt;
      end
    end
  end

  always @* begin
    rd_nxt = 32'h0;
    if (blk_hit(addr_r, `MV_A_FCFG)) begin
      rd_nxt = fcfg_r[addr_r[4:2]];
    end else if (blk_hit(addr_r, `MV_A_ECFG)) begin
      rd_nxt = ecfg_r[addr_r[4:2]];
    end else if (blk_hit(addr_r, `MV_A_ELIM)) begin
      rd_nxt = elim_r[addr_r[4:2]];
    end else if (blk_hit(addr_r, `MV_A_FVAL)) begin
      rd_nxt = {16'h0000, res_r[addr_r[4:2]]};
    end else if (addr_r == `MV_A_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (addr_r == `MV_A_STAT) begin
      rd_nxt = {16'h0000, pass_out, 6'h00, ovr_r, busy};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `MV_RST_WORD;
      ovr_r  <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        fcfg_r[i] <= `MV_RST_WORD;
        ecfg_r[i] <= `MV_RST_WORD;
        elim_r[i] <= `MV_RST_WORD;
      end
    end else begin
      if (wr_pend_r) begin
        if (blk_hit(addr_r, `MV_A_FCFG)) begin
          fcfg_r[addr_r[4:2]] <= hwdata;
        end else if (blk_hit(addr_r, `MV_A_ECFG)) begin
          ecfg_r[addr_r[4:2]] <= hwdata;
        end else if (blk_hit(addr_r, `MV_A_ELIM)) begin
          elim_r[addr_r[4:2]] <= hwdata;
        end else if (addr_r == `MV_A_CTRL) begin
          ctrl_r <= {30'h0, hwdata[1:0]};
        end
      end
      // Overrun set beats a same-cycle clear
      if (meas_valid & busy) begin
        ovr_r <= 1'b1;
      end else if (wr_pend_r && (addr_r == `MV_A_STAT) &&
                   hwdata[`MV_ST_OVR]) begin
        ovr_r <= 1'b0;
      end
    end
  end

  always @* begin
    for (f = 0; f < 8; f = f + 1) begin
      ecfg_flat[f*32 +: 32] = ecfg_r[f];
      elim_flat[f*32 +: 32] = elim_r[f];
      filt_flat[f*16 +: 16] = res_r[f];
    end
  end

  // ----------------------------------------------------------------
  // Filter engine, channels in turn, one pass per measurement
  // ----------------------------------------------------------------
  wire [31:0] fc    = fcfg_r[ch_r];
  wire [2:0]  ftype = fc[`MV_FC_TYPE];
  wire [9:0]  fsize = fc[`MV_FC_SIZE];
  wire [10:0] fbase = fc[`MV_FC_BASE];
  wire signed [15:0] srcv = raw_r[fc[`MV_FC_SRC]*16 +: 16];
  wire        f_act = (ftype != `MV_FT_OFF) && (fsize != 10'h000);
  wire [9:0]  fill  = fill_r[ch_r];
  // Guards a pointer left beyond a shrunk window
  wire [9:0]  wp    = (wptr_r[ch_r] >= fsize) ? 10'h000 : wptr_r[ch_r];
  wire [9:0]  wp1   = wp + 10'h001;
  wire [9:0]  nn    = (fill > fsize) ? fsize : fill;
  wire [9:0]  kmed  = (nn - 10'h001) >> 1;
  wire        last  = (idx_r == nn - 10'h001);
  wire signed [15:0] xv = rd_x;
  wire signed [15:0] cv = rd_c;
  wire [9:0]  lt_n  = lt_r + {9'h000, xv < cv};
  wire [9:0]  le_n  = le_r + {9'h000, xv <= cv};
  wire signed [25:0] acc_n = acc_r + {{10{xv[15]}}, xv};
  wire signed [25:0] avg = acc_n / $signed({16'h0000, nn});
  wire signed [15:0] mn_n = (xv < mn_r) ? xv : mn_r;
  wire signed [15:0] mx_n = (xv > mx_r) ? xv : mx_r;
  wire        mem_we = (st_r == F_SETUP) && f_act;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r    <= F_IDLE;
      ch_r    <= 3'h0;
      idx_r   <= 10'h000;
      jdx_r   <= 10'h000;
      lt_r    <= 10'h000;
      le_r    <= 10'h000;
      acc_r   <= 26'sh0;
      mn_r    <= `MV_VMAX;
      mx_r    <= `MV_VMIN;
      raw_r   <= 128'h0;
      err_r   <= 1'b0;
      fdone_r <= 1'b0;
      for (r = 0; r < 8; r = r + 1) begin
        res_r[r]  <= 16'sh0000;
        wptr_r[r] <= 10'h000;
        fill_r[r] <= 10'h000;
      end
    end else begin
      fdone_r <= 1'b0;
      case (st_r)
        F_IDLE: begin
          // Strobes arriving while busy are dropped, see overrun
          if (meas_valid & ~busy) begin
            raw_r <= meas_vals;
            err_r <= meas_err;
            ch_r  <= 3'h0;
            st_r  <= F_SETUP;
          end
        end
        F_SETUP: begin
          idx_r <= 10'h000;
          jdx_r <= 10'h000;
          lt_r  <= 10'h000;
          le_r  <= 10'h000;
          acc_r <= 26'sh0;
          mn_r  <= `MV_VMAX;
          mx_r  <= `MV_VMIN;
          st_r  <= F_NEXT;
          if (!f_act) begin
            res_r[ch_r] <= 16'sh0000;
          end else begin
            wptr_r[ch_r] <= (wp1 == fsize) ? 10'h000 : wp1;
            fill_r[ch_r] <= (fill >= fsize) ? fsize : fill + 10'h001;
            if (ftype == `MV_FT_DEL) begin
              // Window slot holds the sample from fsize steps back
              res_r[ch_r] <= diff(fc[`MV_FC_DIFF],
                (fill >= fsize) ? $signed(rd_old) : 16'sh0000, srcv);
            end else begin
              st_r <= F_SCAN;
            end
          end
        end
        F_SCAN: begin
          acc_r <= acc_n;
          mn_r  <= mn_n;
          mx_r  <= mx_n;
          lt_r  <= lt_n;
          le_r  <= le_n;
          idx_r <= idx_r + 10'h001;
          if (last) begin
            idx_r <= 10'h000;
            lt_r  <= 10'h000;
            le_r  <= 10'h000;
            st_r  <= F_NEXT;
            // Median by rank: lower middle of the window
            if (ftype == `MV_FT_MED) begin
              if ((lt_n <= kmed) && (le_n > kmed)) begin
                res_r[ch_r] <= diff(fc[`MV_FC_DIFF], cv, srcv);
              end else begin
                jdx_r <= jdx_r + 10'h001;
                st_r  <= F_SCAN;
              end
            end else if (ftype == `MV_FT_MIN) begin
              res_r[ch_r] <= diff(fc[`MV_FC_DIFF], mn_n, srcv);
            end else if (ftype == `MV_FT_MAX) begin
              res_r[ch_r] <= diff(fc[`MV_FC_DIFF], mx_n, srcv);
            end else begin
              res_r[ch_r] <= diff(fc[`MV_FC_DIFF], avg[15:0], srcv);
            end
          end
        end
        default: begin
          if (ch_r == 3'h7) begin
            st_r    <= F_IDLE;
            fdone_r <= 1'b1;
          end else begin
            ch_r <= ch_r + 3'h1;
            st_r <= F_SETUP;
          end
        end
      endcase
    end
  end

  mvfe_smem u_smem (
    .hclk (hclk),
    .we   (mem_we),
    .wa   (fbase + {1'b0, wp}),
    .wd   (srcv),
    .ra0  (fbase + {1'b0, wp}),
    .ra1  (fbase + {1'b0, idx_r}),
    .ra2  (fbase + {1'b0, jdx_r}),
    .rd0  (rd_old),
    .rd1  (rd_x),
    .rd2  (rd_c)
  );

  // ----------------------------------------------------------------
  // Evaluation and output lines
  // ----------------------------------------------------------------
  mvfe_eval u_eval (
    .hclk    (hclk),
    .hresetn (hresetn),
    .step    (fdone_r),
    .raw     (raw_r),
    .filt    (filt_flat),
    .err     (err_r),
    .ecfg    (ecfg_flat),
    .elim    (elim_flat),
    .pass_r  (ev_pass),
    .vld_r   (ev_vld)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pass_out     <= 8'h00;
      result_valid <= 1'b0;
      busy         <= 1'b0;
      dout         <= 8'h00;
    end else begin
      result_valid <= ev_vld;
      if (ev_vld) begin
        pass_out <= ev_pass;
        busy     <= 1'b0;
      end else if (meas_valid & (st_r == F_IDLE)) begin
        busy <= 1'b1;
      end
      // Disabled lines sit low; results stay readable
      if (ctrl_r[`MV_CT_EN]) begin
        dout <= pass_out ^ {8{ctrl_r[`MV_CT_LINV]}};
      end else begin
        dout <= 8'h00;
      end
    end
  end
endmodule

// File: verif/mvfe_ctrl_model.sv
// Machine controller model reading the pass/fail output lines.
// Assumes lines settle the cycle after the result strobe.
`timescale 1ns/1ps
module mvfe_ctrl_model (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Lines from the block
  input  wire [7:0] dout,
  input  wire       result_valid,
  // Latched view
  output reg  [7:0] lines_seen_r
);
  reg rv_d_r;
  // Latch one cycle late: lines follow pass bits by a register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rv_d_r       <= 1'b0;
      lines_seen_r <= 8'h00;
    end else begin
      rv_d_r <= result_valid;
      if (rv_d_r)
        lines_seen_r <= dout;
    end
  end
endmodule

// File: verif/mvfe_props.sv
// Port checker for the filter and evaluation block.
// Assumes it is bound into mvfe_top, one clock domain.
`timescale 1ns/1ps
module mvfe_props (
  // Clock and reset
  input wire        hclk,
  input wire        hresetn,
  // Bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Measurement
  input wire        meas_valid,
  input wire [7:0]  pass_out,
  input wire        result_valid,
  input wire        busy
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take;
  assign take = hsel & htrans[1] & hready;
  // ------------------------------------------------------------
  // Bus
  // ------------------------------------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write was stretched");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data moved outside a read");
  // ------------------------------------------------------------
  // Measurement stepping
  // ------------------------------------------------------------
  a_pulse_one: assert property (result_valid |=> !result_valid)
    else $error("result strobe too long");
  a_busy_set: assert property (meas_valid && !busy |=> busy)
    else $error("strobe not accepted");
  a_busy_hold: assert property (busy |=> busy || result_valid)
    else $error("busy dropped without result");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:1000] result_valid)
    else $error("result never came");
  a_done_idle: assert property (result_valid |-> !busy)
    else $error("busy with result strobe");
  a_pass_hold: assert property ($changed(pass_out) |-> result_valid)
    else $error("pass bits moved between results");
  c_result: cover property (result_valid);
  c_read: cover property (take && !hwrite);
  c_overrun: cover property (meas_valid && busy);
endmodule
bind mvfe_top mvfe_props mvfe_props_i (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .meas_valid, .pass_out,
  .result_valid, .busy);

// File: verif/testbench.sv
// Self-checking bench for mvfe_top with a controller model.
// Assumes AHB-Lite single slave, hready fed from hreadyout.
`timescale 1ns/1ps
module testbench;
  localparam [255:0] ECT = {32'h440, 32'h8, 32'h1d0000, 32'h1c0000,
                            32'h190000, 32'h10, 32'h20, 32'h0};
  localparam [63:0]  TBL = {16'd21, 16'd20, 16'd10, 16'd9};
  reg          hclk, hresetn, hsel, hwrite, meas_valid, meas_err;
  reg  [31:0]  haddr, hwdata, rdat;
  reg  [1:0]   htrans;
  reg  [127:0] meas_vals;
  wire [31:0]  hrdata;
  wire         hreadyout, hresp, result_valid, busy;
  wire [7:0]   dout, pass_out, lines_seen_r;
  integer      err_count, comparisons, i, cnt3, hold4, k5;
  reg  [15:0]  prev, lastm, ex;
  reg  [7:0]   lastp;
  reg  [15:0]  expq[$];
  mvfe_top mvfe_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_valid(meas_valid),
    .meas_vals(meas_vals), .meas_err(meas_err), .dout(dout),
    .pass_out(pass_out), .result_valid(result_valid), .busy(busy));
  mvfe_ctrl_model mvfe_ctrl_model_i (.hclk(hclk), .hresetn(hresetn),
    .dout(dout), .result_valid(result_valid), .lines_seen_r(lines_seen_r));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Sampled at the falling edge, so the next rising edge sees it
  task wait_rdy;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    @(posedge hclk);
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  function logic inr(input [15:0] x);
    inr = (x >= 16'd10) && (x <= 16'd20);
  endfunction
  // Reference for the eight evaluators, then one strobe, and a second strobe while busy when ovr is set
  task meas(input [15:0] v, input e, input ovr, input [1:0] ctl);
    reg a, o4;
    a = inr(v);
    lastm = (prev > v) ? prev : v;
    prev = v;
    cnt3 = a ? cnt3 + 1 : 0;
    k5 = k5 + 1;
    o4 = a && hold4 == 0;
    hold4 = !a ? 2 : (hold4 > 0 ? hold4 - 1 : 0);
    lastp = {a & ~e, inr(lastm), k5 % 3 == 0, o4, cnt3 >= 3, ~e, ~a, a};
    expq.push_back({lastp, ctl[0] ? lastp ^ {8{ctl[1]}} : 8'h00});
    meas_vals  <= {8{v}};
    meas_err   <= e;
    meas_valid <= 1'b1;
    @(posedge hclk);
    meas_valid <= 1'b0;
    if (ovr) begin
      @(posedge hclk);
      meas_valid <= 1'b1;
      @(posedge hclk);
      meas_valid <= 1'b0;
    end
    do @(negedge hclk); while (result_valid !== 1'b1);
    @(posedge hclk);
  endtask
  // ------------------------------------------------------------
  // Result monitor
  // ------------------------------------------------------------
  always @(negedge hclk) begin
    if (result_valid === 1'b1) begin
      ex = expq.pop_front();
      chk(pass_out, ex[15:8], "pass_out");
      @(negedge hclk);
      @(negedge hclk);
      chk(lines_seen_r, ex[7:0], "lines");
    end
  end
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    $display("watchdog expired");
    report_and_stop;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    meas_valid = 1'b0;
    meas_err = 1'b0;
    meas_vals = 128'h0;
    err_count = 0;
    comparisons = 0;
    cnt3 = 0;
    hold4 = 0;
    k5 = 0;
    prev = 16'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(32'ha76ba94f));
    bus(0, 12'h060, 32'h0);
    chk(rdat, 32'h0, "ctrl reset");
    bus(1, 12'h0f0, 32'hffffffff);
    bus(0, 12'h0f0, 32'h0);
    chk(rdat, 32'h0, "unmapped");
    $display("test registers done");
    bus(1, 12'h000, 32'h205);
    for (i = 0; i < 8; i++) begin
      bus(1, 12'h040 + 4 * i, 32'h0014000a);
      bus(1, 12'h020 + 4 * i, ECT[32*i +: 32]);
      bus(0, 12'h020 + 4 * i, 32'h0);
      chk(rdat, ECT[32*i +: 32], "ecfg");
    end
    for (i = 0; i < 24; i++) begin
      if (i == 8)
        bus(1, 12'h060, 32'h1);
      if (i == 16)
        bus(1, 12'h060, 32'h3);
      meas(i < 4 ? TBL[16*i +: 16] : 16'($urandom_range(31, 0)),
           $urandom_range(3, 0) == 0, i == 5, i < 8 ? 2'd0 : (i < 16 ? 2'd1 : 2'd3));
      if (i == 5) begin
        bus(0, 12'h064, 32'h0);
        chk(rdat, {16'h0, lastp, 8'h02}, "stat overrun");
        bus(1, 12'h064, 32'h2);
        bus(0, 12'h064, 32'h0);
        chk(rdat, {16'h0, lastp, 8'h00}, "stat cleared");
      end
    end
    $display("test measurements done");
    repeat (3) @(posedge hclk);
    bus(0, 12'h080, 32'h0);
    chk(rdat, {16'h0, lastm}, "filter value");
    $display("test filter readback done");
    report_and_stop;
  end
endmodule
